// *** shared/flash_store_consts.svh ***
// Constants of the flash store command handler: geometry, frame fields, command codes, timing.
// Assumes it is included by bare name in every file that needs these figures.
`ifndef FLASH_STORE_CONSTS_SVH
`define FLASH_STORE_CONSTS_SVH

`define FS_NUM_BLOCKS 16'h0077
`define FS_BLOCK_BYTES 16'h0200
`define FS_STORE_BYTES 16'hee00
`define FS_ERASED_BYTE 8'hff
`define FS_CLUSTER_ID 16'h0023
`define FS_DEVICE_EP 8'he6
`define FS_HDR_BYTES 16'h0008

`define FS_OFS_CMD 4'h0
`define FS_OFS_OPT 4'h1
`define FS_OFS_BLK_HI 4'h2
`define FS_OFS_BLK_LO 4'h3
`define FS_OFS_IDX_HI 4'h4
`define FS_OFS_IDX_LO 4'h5
`define FS_OFS_CNT_HI 4'h6
`define FS_OFS_CNT_LO 4'h7

`define FS_CMD_PLATFORM 8'h00
`define FS_CMD_ERASE 8'h01
`define FS_CMD_WRITE 8'h02
`define FS_CMD_ERASE_WRITE 8'h03
`define FS_CMD_READ 8'h04
`define FS_CMD_VERIFY 8'h05
`define FS_CMD_VERIFY_INSTALL 8'h06

`define FS_INSTALL_TIME_S 32'h0000_0008
`define FS_CLK_HZ 32'h0262_5a00
`define FS_INSTALL_CYCLES (`FS_INSTALL_TIME_S * `FS_CLK_HZ)

`endif

// *** shared/flash_store_pkg.sv ***
// Types of the flash store command handler: controller states and state records.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_store_pkg;

  typedef enum logic [2:0] {
    ST_HDR = 3'b000,
    ST_EXEC = 3'b001,
    ST_DATA = 3'b011,
    ST_RESP = 3'b010,
    ST_INSTALL = 3'b110,
    ST_ERASE = 3'b101,
    ST_DRAIN = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t state;
    logic [3:0] hdr_cnt;
    logic [7:0] cmd;
    logic [15:0] block;
    logic [15:0] index;
    logic [15:0] count;
    logic [15:0] out_len;
    logic [15:0] data_cnt;
    logic [15:0] resp_cnt;
    logic [15:0] erase_addr;
    logic [15:0] erase_left;
    logic [15:0] img_len;
    logic [7:0] src_ep;
    logic bcast;
    logic frame_done;
    logic err;
    logic img_broken;
    logic rx_ready;
    logic tx_valid;
    logic tx_last;
    logic tx_explicit;
    logic [7:0] tx_data;
    logic [7:0] tx_ep;
    logic install_start;
    logic install_busy;
    logic self_reset;
    logic route_clear;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
  } ctrl_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] cnt;
  } timer_t;

endpackage

// *** shared/store_port_if.sv ***
// Port between the command controller and the byte store.
// Assumes a single clock; reads are combinational, writes take effect at the clock edge.
`timescale 1ns/1ps
interface store_port_if;
  logic wr_en;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  logic [15:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** logic/store_memory.sv ***
// Byte array that stands for the non-volatile store.
// Assumes the controller keeps write addresses inside the store.
`timescale 1ns/1ps
`include "flash_store_consts.svh"
module store_memory (
  input wire logic core_clk, // System clock.
  store_port_if.mem port // Read and write port.
);
  logic [7:0] mem_r [0:`FS_STORE_BYTES-1];

  always_ff @(posedge core_clk) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
  end

  // Addresses past the end read as erased so a stray read never yields unknowns.
  assign port.rd_data = (port.rd_addr < `FS_STORE_BYTES) ? mem_r[port.rd_addr] : `FS_ERASED_BYTE;
endmodule

// *** logic/install_timer.sv ***
// Counts out the installation time after a start pulse and pulses done at its end.
// Assumes start is a one-cycle pulse while the timer is idle.
`timescale 1ns/1ps
`include "flash_store_consts.svh"
module install_timer
  import flash_store_pkg::*;
#(
  parameter int unsigned CYCLES = `FS_INSTALL_CYCLES
) (
  input wire logic core_clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic start, // Begin counting.
  output logic done // One-cycle pulse at the end of the count.
);
  timer_t t_r;
  timer_t t_nxt;

  always_comb begin
    t_nxt = t_r;
    t_nxt.done = 1'b0;
    if (t_r.busy) begin
      if (t_r.cnt == CYCLES - 32'h1) begin
        t_nxt.busy = 1'b0;
        t_nxt.done = 1'b1;
        t_nxt.cnt = 32'h0;
      end else begin
        t_nxt.cnt = t_r.cnt + 32'h1;
      end
    end else if (start) begin
      t_nxt.busy = 1'b1;
      t_nxt.cnt = 32'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign done = t_r.done;
endmodule

// *** logic/flash_store_command_handler.sv ***
// Command interpreter for the general flash store and the firmware update flow.
// Assumes frame attributes (cluster, endpoints, broadcast) stay steady through each frame.
`timescale 1ns/1ps
`include "flash_store_consts.svh"
module flash_store_command_handler
  import flash_store_pkg::*;
#(
  parameter int unsigned INSTALL_CYCLES = `FS_INSTALL_CYCLES
) (
  input wire logic core_clk, // System clock, 40 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic rx_valid, // Payload byte offered.
  input wire logic [7:0] rx_data, // Payload byte.
  input wire logic rx_last, // Last payload byte of the frame.
  input wire logic [15:0] rx_cluster, // Cluster identifier of the frame.
  input wire logic [7:0] rx_dst_ep, // Destination endpoint of the frame.
  input wire logic [7:0] rx_src_ep, // Source endpoint of the frame.
  input wire logic rx_broadcast, // Frame was broadcast.
  output logic rx_ready, // Payload byte accepted.
  input wire logic api_mode, // Requester has API mode active.
  input wire logic explicit_mode, // Requester has explicit API mode enabled.
  output logic tx_valid, // Response byte offered.
  output logic [7:0] tx_data, // Response byte.
  output logic tx_last, // Last response byte.
  output logic [7:0] tx_dst_ep, // Endpoint the response goes to.
  output logic tx_explicit, // Response goes out as explicit receive indicator.
  input wire logic tx_ready, // Response byte accepted.
  output logic install_busy, // Installation in progress.
  output logic self_reset, // One-cycle pulse: device resets.
  output logic route_clear // One-cycle pulse: learned routes dropped.
);
  store_port_if sp ();
  ctrl_t s_r;
  ctrl_t s_nxt;
  logic install_done;
  logic take;
  logic [15:0] resp_total;
  logic [15:0] rd_addr;
  logic [7:0] resp_byte;
  logic img_ok;

  store_memory u_mem (
    .core_clk(core_clk),
    .port(sp)
  );

  install_timer #(
    .CYCLES(INSTALL_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(s_r.install_start),
    .done(install_done)
  );

  function automatic logic [15:0] byte_addr(input logic [15:0] blk, input logic [15:0] idx);
    byte_addr = {blk[6:0], 9'h000} + idx;
  endfunction

  function automatic logic range_err(input logic [15:0] blk, input logic [15:0] idx,
                                     input logic [15:0] cnt);
    range_err = (blk >= `FS_NUM_BLOCKS) ||
                (({1'b0, idx} + {1'b0, cnt}) > {1'b0, `FS_BLOCK_BYTES});
  endfunction

  assign take = rx_valid && s_r.rx_ready;
  assign resp_total = `FS_HDR_BYTES + s_r.out_len;
  assign rd_addr = byte_addr(s_r.block, s_r.index) + (s_r.resp_cnt - `FS_HDR_BYTES);
  assign img_ok = (s_r.img_len != 16'h0000) && !s_r.img_broken;

  always_comb begin
    resp_byte = sp.rd_data;
    if (s_r.resp_cnt < `FS_HDR_BYTES) begin
      case (s_r.resp_cnt[3:0])
        `FS_OFS_CMD: resp_byte = s_r.cmd;
        `FS_OFS_OPT: resp_byte = {7'h00, s_r.err};
        `FS_OFS_BLK_HI: resp_byte = s_r.block[15:8];
        `FS_OFS_BLK_LO: resp_byte = s_r.block[7:0];
        `FS_OFS_IDX_HI: resp_byte = s_r.index[15:8];
        `FS_OFS_IDX_LO: resp_byte = s_r.index[7:0];
        `FS_OFS_CNT_HI: resp_byte = s_r.out_len[15:8];
        default: resp_byte = s_r.out_len[7:0];
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_en = 1'b0;
    s_nxt.install_start = 1'b0;
    s_nxt.self_reset = 1'b0;
    s_nxt.route_clear = 1'b0;
    case (s_r.state)
      ST_HDR: begin
        if (take) begin
          s_nxt.frame_done = rx_last;
          s_nxt.hdr_cnt = s_r.hdr_cnt + 4'h1;
          case (s_r.hdr_cnt)
            `FS_OFS_CMD: begin
              s_nxt.cmd = rx_data;
              s_nxt.src_ep = rx_src_ep;
              s_nxt.bcast = rx_broadcast;
            end
            `FS_OFS_BLK_HI: s_nxt.block[15:8] = rx_data;
            `FS_OFS_BLK_LO: s_nxt.block[7:0] = rx_data;
            `FS_OFS_IDX_HI: s_nxt.index[15:8] = rx_data;
            `FS_OFS_IDX_LO: s_nxt.index[7:0] = rx_data;
            `FS_OFS_CNT_HI: s_nxt.count[15:8] = rx_data;
            `FS_OFS_CNT_LO: s_nxt.count[7:0] = rx_data;
            default: s_nxt.hdr_cnt = s_r.hdr_cnt + 4'h1;
          endcase
          // Frames for another cluster or endpoint are swallowed whole.
          if (s_r.hdr_cnt == `FS_OFS_CMD &&
              (rx_cluster != `FS_CLUSTER_ID || rx_dst_ep != `FS_DEVICE_EP)) begin
            s_nxt.hdr_cnt = 4'h0;
            if (!rx_last) begin
              s_nxt.state = ST_DRAIN;
            end
          end else if (s_r.hdr_cnt == `FS_OFS_CNT_LO) begin
            s_nxt.hdr_cnt = 4'h0;
            s_nxt.state = ST_EXEC;
          end else if (rx_last) begin
            s_nxt.hdr_cnt = 4'h0;
          end
        end
      end
      ST_EXEC: begin
        s_nxt.err = 1'b0;
        s_nxt.out_len = 16'h0000;
        s_nxt.data_cnt = 16'h0000;
        s_nxt.resp_cnt = 16'h0000;
        s_nxt.state = ST_RESP;
        case (s_r.cmd)
          `FS_CMD_PLATFORM: begin
            s_nxt.block = `FS_NUM_BLOCKS;
            s_nxt.index = `FS_BLOCK_BYTES;
          end
          `FS_CMD_ERASE: begin
            if (s_r.count == 16'h0000) begin
              // A full erase also starts a fresh image.
              s_nxt.erase_addr = 16'h0000;
              s_nxt.erase_left = `FS_STORE_BYTES;
              s_nxt.img_len = 16'h0000;
              s_nxt.img_broken = 1'b0;
              s_nxt.state = ST_ERASE;
            end else if (s_r.block >= `FS_NUM_BLOCKS) begin
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.erase_addr = byte_addr(s_r.block, 16'h0000);
              s_nxt.erase_left = `FS_BLOCK_BYTES;
              if (byte_addr(s_r.block, 16'h0000) < s_r.img_len) begin
                s_nxt.img_broken = 1'b1;
              end
              s_nxt.state = ST_ERASE;
            end
          end
          `FS_CMD_WRITE, `FS_CMD_ERASE_WRITE: begin
            if (range_err(s_r.block, s_r.index, s_r.count)) begin
              s_nxt.err = 1'b1;
              s_nxt.state = s_r.frame_done ? ST_RESP : ST_DATA;
            end else if (s_r.cmd == `FS_CMD_ERASE_WRITE) begin
              s_nxt.erase_addr = byte_addr(s_r.block, 16'h0000);
              s_nxt.erase_left = `FS_BLOCK_BYTES;
              if (byte_addr(s_r.block, 16'h0000) < s_r.img_len) begin
                s_nxt.img_broken = 1'b1;
              end
              s_nxt.state = ST_ERASE;
            end else if (s_r.frame_done) begin
              s_nxt.err = (s_r.count != 16'h0000);
            end else begin
              s_nxt.state = ST_DATA;
            end
          end
          `FS_CMD_READ: begin
            if (range_err(s_r.block, s_r.index, s_r.count)) begin
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.out_len = s_r.count;
            end
          end
          `FS_CMD_VERIFY, `FS_CMD_VERIFY_INSTALL: begin
            s_nxt.err = !img_ok;
          end
          default: begin
            s_nxt.err = 1'b1;
          end
        endcase
      end
      ST_ERASE: begin
        s_nxt.wr_en = 1'b1;
        s_nxt.wr_addr = s_r.erase_addr;
        s_nxt.wr_data = `FS_ERASED_BYTE;
        s_nxt.erase_addr = s_r.erase_addr + 16'h0001;
        s_nxt.erase_left = s_r.erase_left - 16'h0001;
        if (s_r.erase_left == 16'h0001) begin
          s_nxt.state = ST_RESP;
          if (s_r.cmd == `FS_CMD_ERASE_WRITE) begin
            if (!s_r.frame_done) begin
              s_nxt.state = ST_DATA;
            end else begin
              s_nxt.err = (s_r.count != 16'h0000);
            end
          end
        end
      end
      ST_DATA: begin
        if (take) begin
          if (s_r.data_cnt < s_r.count) begin
            s_nxt.data_cnt = s_r.data_cnt + 16'h0001;
            if (!s_r.err) begin
              s_nxt.wr_en = 1'b1;
              s_nxt.wr_addr = byte_addr(s_r.block, s_r.index) + s_r.data_cnt;
              s_nxt.wr_data = rx_data;
              // Image stays intact only while bytes land strictly in order.
              if (byte_addr(s_r.block, s_r.index) + s_r.data_cnt == s_r.img_len) begin
                s_nxt.img_len = s_r.img_len + 16'h0001;
              end else begin
                s_nxt.img_broken = 1'b1;
              end
            end
          end
          if (rx_last) begin
            s_nxt.frame_done = 1'b1;
            s_nxt.state = ST_RESP;
            if (s_r.data_cnt + 16'h0001 < s_r.count) begin
              s_nxt.err = 1'b1;
            end
          end
        end
      end
      ST_RESP: begin
        if (s_r.bcast || (s_r.resp_cnt == resp_total && (!s_r.tx_valid || tx_ready))) begin
          s_nxt.tx_valid = 1'b0;
          s_nxt.tx_last = 1'b0;
          if (s_r.cmd == `FS_CMD_VERIFY_INSTALL && !s_r.err) begin
            s_nxt.install_start = 1'b1;
            s_nxt.install_busy = 1'b1;
            s_nxt.state = ST_INSTALL;
          end else begin
            s_nxt.state = s_r.frame_done ? ST_HDR : ST_DRAIN;
          end
        end else if (!s_r.tx_valid || tx_ready) begin
          s_nxt.tx_valid = 1'b1;
          s_nxt.tx_data = resp_byte;
          s_nxt.tx_last = (s_r.resp_cnt == resp_total - 16'h0001);
          s_nxt.tx_ep = s_r.src_ep;
          s_nxt.tx_explicit = (s_r.src_ep == `FS_DEVICE_EP || explicit_mode) && api_mode;
          s_nxt.resp_cnt = s_r.resp_cnt + 16'h0001;
        end
      end
      ST_INSTALL: begin
        // Everything offered meanwhile is taken and dropped.
        if (take) begin
          s_nxt.frame_done = rx_last;
        end
        if (install_done) begin
          s_nxt.install_busy = 1'b0;
          s_nxt.self_reset = 1'b1;
          s_nxt.route_clear = 1'b1;
          s_nxt.state = s_nxt.frame_done ? ST_HDR : ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (take && rx_last) begin
          s_nxt.state = ST_HDR;
        end
      end
      default: begin
        s_nxt.state = ST_HDR;
      end
    endcase
    s_nxt.rx_ready = (s_nxt.state == ST_HDR) || (s_nxt.state == ST_DATA) ||
                     (s_nxt.state == ST_DRAIN) || (s_nxt.state == ST_INSTALL);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sp.wr_en = s_r.wr_en;
  assign sp.wr_addr = s_r.wr_addr;
  assign sp.wr_data = s_r.wr_data;
  assign sp.rd_addr = rd_addr;
  assign rx_ready = s_r.rx_ready;
  assign tx_valid = s_r.tx_valid;
  assign tx_data = s_r.tx_data;
  assign tx_last = s_r.tx_last;
  assign tx_dst_ep = s_r.tx_ep;
  assign tx_explicit = s_r.tx_explicit;
  assign install_busy = s_r.install_busy;
  assign self_reset = s_r.self_reset;
  assign route_clear = s_r.route_clear;
endmodule

// *** verification/flash_store_handler_chk.sv ***
// Concurrent checks on the ports of the flash store command handler.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module flash_store_handler_chk #(
  parameter int unsigned INSTALL_CYCLES = 20
) (
  input wire logic core_clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic rx_valid, // Byte offered.
  input wire logic [7:0] rx_data, // Byte.
  input wire logic rx_last, // Frame end.
  input wire logic [7:0] rx_src_ep, // Source endpoint.
  input wire logic rx_broadcast, // Broadcast frame.
  input wire logic rx_ready, // Byte taken.
  input wire logic api_mode, // API mode.
  input wire logic explicit_mode, // Explicit mode.
  input wire logic tx_valid, // Reply byte offered.
  input wire logic [7:0] tx_data, // Reply byte.
  input wire logic tx_last, // Last reply byte.
  input wire logic [7:0] tx_dst_ep, // Reply endpoint.
  input wire logic tx_explicit, // Explicit indicator.
  input wire logic tx_ready, // Reply byte taken.
  input wire logic install_busy, // Installing.
  input wire logic self_reset, // Reset pulse.
  input wire logic route_clear // Route drop pulse.
);
  logic first_r;
  logic bc_r;
  logic [7:0] cmd_r;
  logic [7:0] src_r;
  logic [3:0] pos_r;
  logic [31:0] busy_r;

  // Remembers the attributes of the frame that a reply belongs to.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_r <= 1'b1;
      bc_r <= 1'b0;
      cmd_r <= 8'h00;
      src_r <= 8'h00;
      pos_r <= 4'h0;
      busy_r <= 32'h0;
    end else begin
      if (rx_valid && rx_ready) begin
        first_r <= rx_last;
        if (first_r) begin
          cmd_r <= rx_data;
          src_r <= rx_src_ep;
          bc_r <= rx_broadcast;
        end
      end
      if (tx_valid && tx_ready) begin
        pos_r <= tx_last ? 4'h0 : pos_r + {3'h0, pos_r != 4'hf};
      end
      busy_r <= install_busy ? busy_r + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed before it was taken");
  chk_bcast_silent: assert property (tx_valid |-> !bc_r)
    else $error("reply sent for a broadcast request");
  chk_reply_ep: assert property (tx_valid |-> tx_dst_ep == src_r)
    else $error("reply endpoint differs from request source");
  chk_explicit_flag: assert property (
    tx_valid |-> tx_explicit == ((src_r == 8'he6 || explicit_mode) && api_mode))
    else $error("explicit indicator flag wrong");
  chk_echo_code: assert property (tx_valid && pos_r == 4'h0 |-> tx_data == cmd_r)
    else $error("reply byte 0 is not the command code");
  chk_status_bits: assert property (tx_valid && pos_r == 4'h1 |-> tx_data[7:1] == 7'h00)
    else $error("reserved status bits set");
  chk_install_quiet: assert property (install_busy |-> !tx_valid)
    else $error("reply sent during installation");
  chk_reset_pair: assert property (self_reset |-> route_clear && $past(install_busy))
    else $error("self reset without route clear or installation");
  chk_reset_pulse: assert property ($rose(self_reset) |=> !self_reset && !install_busy)
    else $error("self reset pulse too long or busy stays");
  chk_install_time: assert property (busy_r <= INSTALL_CYCLES + 32'd8)
    else $error("installation runs past its time");
endmodule

bind flash_store_command_handler flash_store_handler_chk #(.INSTALL_CYCLES(INSTALL_CYCLES)) chk (
  .core_clk, .rst_n, .rx_valid, .rx_data, .rx_last, .rx_src_ep, .rx_broadcast, .rx_ready,
  .api_mode, .explicit_mode, .tx_valid, .tx_data, .tx_last, .tx_dst_ep, .tx_explicit,
  .tx_ready, .install_busy, .self_reset, .route_clear
);

// *** verification/requester_model.sv ***
// Requester that sends storage command frames and sinks the replies.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
module requester_model (
  input wire logic core_clk, // Clock.
  input wire logic rx_ready, // Device takes a byte.
  output logic rx_valid, // Byte offered.
  output logic [7:0] rx_data, // Byte.
  output logic rx_last, // Last byte of frame.
  input wire logic tx_valid, // Reply byte offered.
  input wire logic [7:0] tx_data, // Reply byte.
  input wire logic tx_last, // Last reply byte.
  input wire logic slow, // Sink stalls every other cycle.
  output logic tx_ready // Reply byte taken.
);
  logic [7:0] resp[$];
  logic rdy_s;
  int frames = 0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end

  // A registered ready seen at the falling edge holds at the next rising edge.
  always @(negedge core_clk) rdy_s = rx_ready;

  always @(posedge core_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      resp.push_back(tx_data);
      if (tx_last) frames++;
    end
  end

  task automatic send(input logic [7:0] code, input logic [15:0] blk, idx, cnt,
                      input logic [7:0] dat[$]);
    logic [7:0] b[$];
    b = {code, 8'h00, blk[15:8], blk[7:0], idx[15:8], idx[7:0], cnt[15:8], cnt[7:0]};
    b = {b, dat};
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      rx_last <= (i == b.size() - 1);
      do @(posedge core_clk); while (!rdy_s);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b[b.size() - 1];
  endtask
endmodule

// *** verification/flash_store_command_handler_tb.sv ***
// Self-checking bench for the flash store command handler.
// Assumes a short install count and the requester model on the frame side.
`timescale 1ns/1ps
module flash_store_command_handler_tb;
  localparam int unsigned INST = 60;
  localparam int LIMIT = 80000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bcast = 1'b0;
  logic slow = 1'b0;
  logic api_mode = 1'b1;
  logic explicit_mode = 1'b0;
  logic [7:0] src_ep = 8'he6;
  logic [7:0] dst_ep = 8'he6;
  logic [15:0] cluster = 16'h0023;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_explicit, tx_ready;
  logic install_busy, self_reset, route_clear, last_exp, rc_ok;
  logic [7:0] rx_data, tx_data, tx_dst_ep, last_ep;
  logic [7:0] none[$];
  logic [7:0] img[$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_reset = 0;
  int busy_cyc = 0;

  flash_store_command_handler #(.INSTALL_CYCLES(INST)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_cluster(cluster), .rx_dst_ep(dst_ep), .rx_src_ep(src_ep),
    .rx_broadcast(bcast), .rx_ready(rx_ready), .api_mode(api_mode),
    .explicit_mode(explicit_mode), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_dst_ep(tx_dst_ep), .tx_explicit(tx_explicit),
    .tx_ready(tx_ready), .install_busy(install_busy), .self_reset(self_reset),
    .route_clear(route_clear));

  requester_model req (
    .core_clk(core_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .slow(slow), .tx_ready(tx_ready));

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      last_ep <= tx_dst_ep;
      last_exp <= tx_explicit;
    end
    if (self_reset) begin
      n_reset <= n_reset + 1;
      rc_ok <= route_clear;
    end
    if (install_busy) busy_cyc <= busy_cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("Error at %0t: run exceeded its cycle limit", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("Checks made: %0d, mismatches: %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Sends one request and compares the whole reply against the expected bytes.
  task automatic xfer(input logic [7:0] code, input logic [15:0] blk, idx, cnt,
                      input logic [7:0] dat[$], input logic [7:0] st,
                      input logic [15:0] rblk, ridx, rcnt, input logic [7:0] rdat[$]);
    logic [7:0] exp[$];
    int n;
    n = req.frames;
    exp = {code, st, rblk[15:8], rblk[7:0], ridx[15:8], ridx[7:0], rcnt[15:8], rcnt[7:0]};
    exp = {exp, rdat};
    req.resp.delete();
    req.send(code, blk, idx, cnt, dat);
    for (int i = 0; i < 70000 && req.frames == n; i++) @(posedge core_clk);
    ck(16'(req.frames - n), 16'h1, "reply count");
    ck(16'(req.resp.size()), 16'(exp.size()), "reply length");
    foreach (exp[i]) ck({8'h00, req.resp[i]}, {8'h00, exp[i]}, "reply byte");
  endtask

  task automatic t_platform();
    logic [7:0] srcs[4] = '{8'he6, 8'h10, 8'h10, 8'he6};
    logic ex[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic api[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic want[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int k = 0; k < 4; k++) begin
      src_ep <= srcs[k];
      explicit_mode <= ex[k];
      api_mode <= api[k];
      slow <= (k == 1);
      @(posedge core_clk);
      xfer(8'h00, 16'h0005, 16'h0006, 16'h0, none, 8'h00, 16'h0077, 16'h0200, 16'h0, none);
      ck({8'h00, last_ep}, {8'h00, srcs[k]}, "reply endpoint");
      ck({15'h0, last_exp}, {15'h0, want[k]}, "explicit flag");
    end
    slow <= 1'b0;
    src_ep <= 8'he6;
    api_mode <= 1'b1;
  endtask

  task automatic t_silent();
    logic [15:0] cl[3] = '{16'h0024, 16'h0023, 16'h0023};
    logic [7:0] ep[3] = '{8'he6, 8'h10, 8'he6};
    logic bc[3] = '{1'b0, 1'b0, 1'b1};
    int n;
    n = req.frames;
    for (int k = 0; k < 3; k++) begin
      cluster <= cl[k];
      dst_ep <= ep[k];
      bcast <= bc[k];
      @(posedge core_clk);
      req.send(8'h00, 16'h0, 16'h0, 16'h0, none);
      repeat (30) @(posedge core_clk);
    end
    cluster <= 16'h0023;
    dst_ep <= 8'he6;
    bcast <= 1'b0;
    ck(16'(req.frames - n), 16'h0, "replies to foreign or broadcast frames");
  endtask

  task automatic t_store();
    xfer(8'h01, 16'h0, 16'h0, 16'h0, none, 8'h00, 16'h0, 16'h0, 16'h0, none);
    xfer(8'h02, 16'h0, 16'h0, 16'h5, img[0:4], 8'h00, 16'h0, 16'h0, 16'h0, none);
    xfer(8'h02, 16'h0, 16'h5, 16'h3, img[5:7], 8'h00, 16'h0, 16'h5, 16'h0, none);
    slow <= 1'b1;
    xfer(8'h04, 16'h0, 16'h2, 16'h4, none, 8'h00, 16'h0, 16'h2, 16'h4, img[2:5]);
    slow <= 1'b0;
    xfer(8'h05, 16'h0, 16'h0, 16'h0, none, 8'h00, 16'h0, 16'h0, 16'h0, none);
    ck({15'h0, install_busy}, 16'h0, "busy after verify");
  endtask

  task automatic t_install();
    int r;
    int b;
    r = n_reset;
    xfer(8'h06, 16'h0, 16'h0, 16'h0, none, 8'h00, 16'h0, 16'h0, 16'h0, none);
    b = req.frames;
    for (int i = 0; i < 20 && !install_busy; i++) @(posedge core_clk);
    req.send(8'h00, 16'h0, 16'h0, 16'h0, none);
    for (int i = 0; i < INST + 40 && n_reset == r; i++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    ck(16'(req.frames - b), 16'h0, "replies during install");
    ck(16'(n_reset - r), 16'h1, "self reset pulses");
    ck({15'h0, rc_ok}, 16'h1, "route clear with reset");
    ck({15'h0, busy_cyc >= INST && busy_cyc <= INST + 8}, 16'h1, "install length");
  endtask

  task automatic t_errors();
    int b;
    logic [7:0] fresh[$];
    fresh = {8'hff, img[6:7]};
    xfer(8'h02, 16'h0, 16'h0, 16'h1, img[0:0], 8'h00, 16'h0, 16'h0, 16'h0, none);
    xfer(8'h02, 16'h76, 16'h1fd, 16'h3, img[0:2], 8'h00, 16'h76, 16'h1fd, 16'h0, none);
    xfer(8'h04, 16'h76, 16'h1fd, 16'h3, none, 8'h00, 16'h76, 16'h1fd, 16'h3, img[0:2]);
    xfer(8'h02, 16'h76, 16'h1fe, 16'h3, img[3:5], 8'h01, 16'h76, 16'h1fe, 16'h0, none);
    xfer(8'h04, 16'h77, 16'h0, 16'h1, none, 8'h01, 16'h77, 16'h0, 16'h0, none);
    xfer(8'h03, 16'h76, 16'h1fe, 16'h2, img[6:7], 8'h00, 16'h76, 16'h1fe, 16'h0, none);
    xfer(8'h04, 16'h76, 16'h1fd, 16'h3, none, 8'h00, 16'h76, 16'h1fd, 16'h3, fresh);
    xfer(8'h07, 16'h0, 16'h0, 16'h0, none, 8'h01, 16'h0, 16'h0, 16'h0, none);
    xfer(8'h05, 16'h0, 16'h0, 16'h0, none, 8'h01, 16'h0, 16'h0, 16'h0, none);
    b = busy_cyc;
    xfer(8'h06, 16'h0, 16'h0, 16'h0, none, 8'h01, 16'h0, 16'h0, 16'h0, none);
    repeat (INST + 20) @(posedge core_clk);
    ck(16'(busy_cyc - b), 16'h0, "install on broken image");
  endtask

  initial begin
    img = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    do_reset();
    t_platform();
    t_silent();
    t_store();
    t_install();
    // The device restarts after installing, so the bench resets it too.
    do_reset();
    t_errors();
    close_out();
  end
endmodule
